/* verilog/rfs_fault_supervisor.sv */
// Startup checks, power-good, overcurrent, overvoltage and lockout supervisor
`timescale 1ns/10ps
`default_nettype none

module rfs_fault_supervisor #(
  parameter int unsigned CLAMP_LOG_CYC  = rfs_pkg::CLAMP_LOG_CYC,
  parameter int unsigned HICCUP_OFF_CYC = rfs_pkg::HICCUP_OFF_CYC,
  parameter int unsigned PG_DELAY_CYC   = rfs_pkg::PG_DELAY_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire rfs_pkg::rfs_pin_type      pins_async,
  input  wire rfs_pkg::rfs_scenario_type scenario,
  input  wire logic [7:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  output logic                           regulate_en,
  output logic                           core_rail_good,
  output logic                           aux_rail_good,
  output logic                           overvoltage_trip,
  output logic                           major_fault_n,
  output logic                           stage_overtemp_warning_n,
  output logic                           overcurrent_clamp_flag,
  output logic                           max_load_current_limit_warning,
  output logic      [3:0]                positive_current_limit,
  output logic                           sinking_current_limit,
  output logic      [3:0]                orthogonal_rebalancing_gain
);

  // ----------
  // Synchronised pins
  // ----------
  rfs_pkg::rfs_pin_type p;
  logic [$bits(rfs_pkg::rfs_pin_type)-1:0] pins_q;

  rfs_sync #(
    .W ($bits(rfs_pkg::rfs_pin_type))
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .d_async (pins_async),
    .q       (pins_q)
  );

  assign p = rfs_pkg::rfs_pin_type'(pins_q);

  // ----------
  // State
  // ----------
  rfs_pkg::rfs_state_type state_ff;
  rfs_pkg::rfs_state_type nxt_state;
  rfs_pkg::rfs_cfg_type   cfg_ff;
  rfs_pkg::rfs_cfg_type   nxt_cfg;
  logic [7:0]             log_ff;
  logic [7:0]             nxt_log;
  logic                   ovp_latch_ff;
  logic                   nxt_ovp_latch;
  logic                   fault_latch_ff;
  logic                   nxt_fault_latch;
  logic [7:0]             rdata_ff;
  logic [7:0]             nxt_rdata;
  logic                   regulate_ff;
  logic                   nxt_regulate;
  logic                   core_good_ff;
  logic                   nxt_core_good;
  logic                   aux_good_ff;
  logic                   nxt_aux_good;
  logic                   hot_n_ff;
  logic                   nxt_hot_n;
  logic                   clamp_flag_ff;
  logic                   nxt_clamp_flag;
  logic                   max_load_current_limit_ff;
  logic                   nxt_max_load_current_limit;
  logic [3:0]             pos_lim_ff;
  logic [3:0]             nxt_pos_lim;
  logic                   sink_lim_ff;
  logic                   nxt_sink_lim;
  logic [3:0]             gain_ff;
  logic [3:0]             nxt_gain;

  logic bias_ok;
  logic active;
  logic init_bad;
  logic en_bad;
  logic ovp_hit;
  logic continuous;
  logic clamp_done;
  logic off_done;
  logic pg_done;
  logic [3:0] sel_raw;

  assign bias_ok    = p.bias_18_ok && p.bias_33_ok;
  assign active     = (state_ff == rfs_pkg::ST_RAMP) || (state_ff == rfs_pkg::ST_REGULATE);
  assign init_bad   = p.phase_current_sense_short || !p.strap_valid || p.core_sense_open
                    || p.aux_positive_sense_open;
  assign en_bad     = p.stage_temp_sense_open || p.phase_fault || p.stage_fault;
  assign ovp_hit    = p.ovp_track || p.ovp_umbrella;
  assign continuous = cfg_ff.oc_mode[rfs_pkg::OC_MODE_CONT_BIT];
  assign sel_raw    = cfg_ff.oc_sel[rfs_pkg::OC_SEL_LSB +: 4];

  // ----------
  // Interval timers
  // ----------
  // Clamp time restarts whenever the clamp lets go
  rfs_interval_timer #(
    .W (rfs_pkg::TIMER_W)
  ) u_clamp_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     (active && p.clamp_on),
    .limit   (CLAMP_LOG_CYC[rfs_pkg::TIMER_W-1:0]),
    .done    (clamp_done)
  );

  rfs_interval_timer #(
    .W (rfs_pkg::TIMER_W)
  ) u_off_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     (state_ff == rfs_pkg::ST_HICCUP_OFF),
    .limit   (HICCUP_OFF_CYC[rfs_pkg::TIMER_W-1:0]),
    .done    (off_done)
  );

  rfs_interval_timer #(
    .W (rfs_pkg::TIMER_W)
  ) u_pg_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     ((state_ff == rfs_pkg::ST_RAMP) && p.vid_start_done),
    .limit   (PG_DELAY_CYC[rfs_pkg::TIMER_W-1:0]),
    .done    (pg_done)
  );

  // ----------
  // Sequencer, latches, log and configuration
  // ----------
  always_comb begin
    nxt_state       = state_ff;
    nxt_cfg         = cfg_ff;
    nxt_log         = log_ff;
    nxt_ovp_latch   = ovp_latch_ff;
    nxt_fault_latch = fault_latch_ff;

    // Software writes; the log is read-only
    if (reg_wr) begin
      unique case (reg_addr)
        rfs_pkg::ADDR_REBAL:    nxt_cfg.rebal    = reg_wdata;
        rfs_pkg::ADDR_OC_MODE:  nxt_cfg.oc_mode  = reg_wdata;
        rfs_pkg::ADDR_OC_SEL:   nxt_cfg.oc_sel   = reg_wdata;
        rfs_pkg::ADDR_SINK_OPT: nxt_cfg.sink_opt = reg_wdata;
        default: ;
      endcase
    end

    unique case (state_ff)
      rfs_pkg::ST_LOCKOUT: begin
        // Held while bias is low: reload scenario, drop latches
        nxt_cfg.rebal    = {scenario.rebal_gain, 4'h0};
        nxt_cfg.oc_mode  = {scenario.continuous_limit_mode, 7'h00};
        nxt_cfg.oc_sel   = {3'h0, scenario.sink_sel, scenario.oc_sel};
        nxt_cfg.sink_opt = rfs_pkg::REG_ZERO;
        nxt_log          = rfs_pkg::REG_ZERO;
        nxt_ovp_latch    = 1'b0;
        nxt_fault_latch  = 1'b0;
        if (bias_ok) begin
          nxt_state = rfs_pkg::ST_INIT_CHECK;
        end
      end
      rfs_pkg::ST_INIT_CHECK: begin
        nxt_log[rfs_pkg::LOG_PHASE_CURRENT_SENSE_SHORT] |= p.phase_current_sense_short;
        nxt_log[rfs_pkg::LOG_STRAP_BAD]    |= !p.strap_valid;
        nxt_log[rfs_pkg::LOG_SENSE_OPEN]   |= p.core_sense_open
                                           | p.aux_positive_sense_open;
        if (init_bad) begin
          nxt_fault_latch = 1'b1;
          nxt_state       = rfs_pkg::ST_HALT;
        end else begin
          nxt_state = rfs_pkg::ST_WAIT_EN;
        end
      end
      rfs_pkg::ST_WAIT_EN: begin
        if (p.vin_ok && p.output_enable_pin) begin
          nxt_state = rfs_pkg::ST_EN_CHECK;
        end
      end
      rfs_pkg::ST_EN_CHECK: begin
        nxt_log[rfs_pkg::LOG_STAGE_TEMP_SENSE_OPEN] |= p.stage_temp_sense_open;
        nxt_log[rfs_pkg::LOG_PHASE_FAULT] |= p.phase_fault;
        nxt_log[rfs_pkg::LOG_STAGE_FAULT] |= p.stage_fault;
        if (en_bad) begin
          nxt_fault_latch = 1'b1;
          nxt_state       = rfs_pkg::ST_HALT;
        end else if (!p.vin_ok || !p.output_enable_pin) begin
          nxt_state = rfs_pkg::ST_WAIT_EN;
        end else begin
          nxt_state = rfs_pkg::ST_RAMP;
        end
      end
      rfs_pkg::ST_RAMP: begin
        if (pg_done) begin
          nxt_state = rfs_pkg::ST_REGULATE;
        end
      end
      rfs_pkg::ST_REGULATE: begin
      end
      rfs_pkg::ST_HICCUP_OFF: begin
        if (off_done) begin
          nxt_state = rfs_pkg::ST_RAMP;
        end
      end
      rfs_pkg::ST_HALT: begin
      end
    endcase

    // Run-time protection while powered or waiting out a hiccup
    if (active || (state_ff == rfs_pkg::ST_HICCUP_OFF)) begin
      if (active && clamp_done) begin
        nxt_log[rfs_pkg::LOG_OVERCURRENT] = 1'b1;
      end
      if (ovp_hit) begin
        nxt_log[rfs_pkg::LOG_OVERVOLTAGE] = 1'b1;
        nxt_ovp_latch = 1'b1;
        nxt_state     = rfs_pkg::ST_HALT;
      end else if (active && (p.stage_temp_sense_low || p.stage_fault)) begin
        nxt_log[rfs_pkg::LOG_STAGE_FAULT] = 1'b1;
        nxt_fault_latch = 1'b1;
        nxt_state       = rfs_pkg::ST_HALT;
      end else if (!p.vin_ok || !p.output_enable_pin) begin
        // Input loss keeps the configuration untouched
        nxt_state = rfs_pkg::ST_WAIT_EN;
      end else if (active && clamp_done && !continuous) begin
        nxt_state = rfs_pkg::ST_HICCUP_OFF;
      end
    end

    // Bias loss wins over everything
    if (!bias_ok) begin
      nxt_state = rfs_pkg::ST_LOCKOUT;
    end
  end

  // ----------
  // Output and read-back values
  // ----------
  always_comb begin
    nxt_regulate  = (nxt_state == rfs_pkg::ST_RAMP)
                 || (nxt_state == rfs_pkg::ST_REGULATE);
    // Core good follows the tolerance comparator only, not VID moves; aux good ignores it
    nxt_core_good = (nxt_state == rfs_pkg::ST_REGULATE) && !p.below_tolerance
                 && !nxt_ovp_latch && !nxt_fault_latch;
    nxt_aux_good  = (nxt_state == rfs_pkg::ST_REGULATE)
                 && !nxt_ovp_latch && !nxt_fault_latch;
    nxt_hot_n     = !(bias_ok && p.stage_hot);
    nxt_clamp_flag = scenario.flag_en && active && p.clamp_on;
    nxt_max_load_current_limit    = active && p.max_load_current_limit_over;
    // Codes past the tenth value saturate at the top step
    nxt_pos_lim   = (sel_raw > rfs_pkg::OC_SEL_MAX) ? rfs_pkg::OC_SEL_MAX : sel_raw;
    nxt_sink_lim  = cfg_ff.oc_sel[rfs_pkg::SINK_SEL_BIT];
    nxt_gain      = cfg_ff.rebal[rfs_pkg::REBAL_GAIN_LSB +: 4];

    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        rfs_pkg::ADDR_REBAL:     nxt_rdata = cfg_ff.rebal;
        rfs_pkg::ADDR_OC_MODE:   nxt_rdata = cfg_ff.oc_mode;
        rfs_pkg::ADDR_OC_SEL:    nxt_rdata = cfg_ff.oc_sel;
        rfs_pkg::ADDR_SINK_OPT:  nxt_rdata = cfg_ff.sink_opt;
        rfs_pkg::ADDR_FAULT_LOG: nxt_rdata = log_ff;
        default:                 nxt_rdata = rfs_pkg::REG_ZERO;
      endcase
    end
  end

  // ----------
  // Registers
  // ----------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff       <= rfs_pkg::ST_LOCKOUT;
      cfg_ff         <= rfs_pkg::CFG_RESET;
      log_ff         <= rfs_pkg::REG_ZERO;
      ovp_latch_ff   <= 1'b0;
      fault_latch_ff <= 1'b0;
      rdata_ff       <= rfs_pkg::REG_ZERO;
      regulate_ff    <= 1'b0;
      core_good_ff   <= 1'b0;
      aux_good_ff    <= 1'b0;
      hot_n_ff       <= 1'b1;
      clamp_flag_ff  <= 1'b0;
      max_load_current_limit_ff      <= 1'b0;
      pos_lim_ff     <= 4'h0;
      sink_lim_ff    <= 1'b0;
      gain_ff        <= 4'h0;
    end else if (ce) begin
      state_ff       <= nxt_state;
      cfg_ff         <= nxt_cfg;
      log_ff         <= nxt_log;
      ovp_latch_ff   <= nxt_ovp_latch;
      fault_latch_ff <= nxt_fault_latch;
      rdata_ff       <= nxt_rdata;
      regulate_ff    <= nxt_regulate;
      core_good_ff   <= nxt_core_good;
      aux_good_ff    <= nxt_aux_good;
      hot_n_ff       <= nxt_hot_n;
      clamp_flag_ff  <= nxt_clamp_flag;
      max_load_current_limit_ff      <= nxt_max_load_current_limit;
      pos_lim_ff     <= nxt_pos_lim;
      sink_lim_ff    <= nxt_sink_lim;
      gain_ff        <= nxt_gain;
    end
  end

  assign reg_rdata                   = rdata_ff;
  assign regulate_en                 = regulate_ff;
  assign core_rail_good              = core_good_ff;
  assign aux_rail_good               = aux_good_ff;
  assign overvoltage_trip            = ovp_latch_ff;
  assign major_fault_n               = !fault_latch_ff;
  assign stage_overtemp_warning_n    = hot_n_ff;
  assign overcurrent_clamp_flag      = clamp_flag_ff;
  assign max_load_current_limit_warning              = max_load_current_limit_ff;
  assign positive_current_limit      = pos_lim_ff;
  assign sinking_current_limit       = sink_lim_ff;
  assign orthogonal_rebalancing_gain = gain_ff;

endmodule // rfs_fault_supervisor
`default_nettype wire

/* verilog/rfs_pkg.sv */
// Shared constants, types and register map of the regulator fault supervisor
package rfs_pkg;

  // ----------
  // Clock and timing
  // ----------
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned TIMER_W         = 24;
  localparam int unsigned CLAMP_LOG_US    = 5000;
  localparam int unsigned HICCUP_OFF_US   = 45000;
  localparam int unsigned PG_DELAY_US     = 1;
  localparam int unsigned CLAMP_LOG_CYC   = CLAMP_LOG_US * CLK_MHZ;
  localparam int unsigned HICCUP_OFF_CYC  = HICCUP_OFF_US * CLK_MHZ;
  localparam int unsigned PG_DELAY_CYC    = PG_DELAY_US * CLK_MHZ;

  // ----------
  // Register offsets
  // ----------
  localparam logic [7:0] ADDR_REBAL       = 8'hB4;
  localparam logic [7:0] ADDR_OC_MODE     = 8'hD2;
  localparam logic [7:0] ADDR_OC_SEL      = 8'hD3;
  localparam logic [7:0] ADDR_SINK_OPT    = 8'hD8;
  localparam logic [7:0] ADDR_FAULT_LOG   = 8'hF9;

  // ----------
  // Field positions and values
  // ----------
  localparam int unsigned OC_MODE_CONT_BIT = 7;
  localparam int unsigned OC_SEL_LSB       = 0;
  localparam int unsigned SINK_SEL_BIT     = 4;
  localparam int unsigned REBAL_GAIN_LSB   = 4;
  localparam logic [3:0]  OC_SEL_MAX       = 4'h9;
  localparam logic [7:0]  REG_ZERO         = 8'h00;

  localparam int unsigned LOG_PHASE_CURRENT_SENSE_SHORT = 0;
  localparam int unsigned LOG_STRAP_BAD    = 1;
  localparam int unsigned LOG_SENSE_OPEN   = 2;
  localparam int unsigned LOG_STAGE_TEMP_SENSE_OPEN  = 3;
  localparam int unsigned LOG_PHASE_FAULT  = 4;
  localparam int unsigned LOG_STAGE_FAULT  = 5;
  localparam int unsigned LOG_OVERCURRENT  = 6;
  localparam int unsigned LOG_OVERVOLTAGE  = 7;

  // ----------
  // Types
  // ----------
  typedef enum logic [2:0] {
    ST_LOCKOUT    = 3'h0,
    ST_INIT_CHECK = 3'h1,
    ST_WAIT_EN    = 3'h2,
    ST_EN_CHECK   = 3'h3,
    ST_RAMP       = 3'h4,
    ST_REGULATE   = 3'h5,
    ST_HICCUP_OFF = 3'h6,
    ST_HALT       = 3'h7
  } rfs_state_type;

  typedef struct packed {
    logic bias_18_ok;
    logic bias_33_ok;
    logic vin_ok;
    logic output_enable_pin;
    logic phase_current_sense_short;
    logic strap_valid;
    logic core_sense_open;
    logic aux_positive_sense_open;
    logic stage_temp_sense_open;
    logic phase_fault;
    logic stage_fault;
    logic stage_temp_sense_low;
    logic stage_hot;
    logic ovp_track;
    logic ovp_umbrella;
    logic below_tolerance;
    logic vid_start_done;
    logic clamp_on;
    logic max_load_current_limit_over;
  } rfs_pin_type;

  typedef struct packed {
    logic [3:0] oc_sel;
    logic       sink_sel;
    logic       continuous_limit_mode;
    logic       flag_en;
    logic [3:0] rebal_gain;
  } rfs_scenario_type;

  typedef struct packed {
    logic [7:0] rebal;
    logic [7:0] oc_mode;
    logic [7:0] oc_sel;
    logic [7:0] sink_opt;
  } rfs_cfg_type;

  localparam rfs_cfg_type CFG_RESET = '{rebal: 8'h00, oc_mode: 8'h00,
                                        oc_sel: 8'h00, sink_opt: 8'h00};

endpackage

/* verilog/rfs_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module rfs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage is read by the second stage only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else if (ce) begin
      meta_ff <= d_async;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // rfs_sync
`default_nettype wire

/* verilog/rfs_interval_timer.sv */
// Cycle counter that flags when a run level has held for a given count
`timescale 1ns/10ps
`default_nettype none
module rfs_interval_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic         done_ff;
  logic         nxt_done;

  // Restarts from zero whenever run drops, saturates at the limit
  always_comb begin
    nxt_count = count_ff;
    if (!run) begin
      nxt_count = '0;
    end else if (count_ff < limit) begin
      nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
    end
    nxt_done = run && (nxt_count == limit);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
    end else if (ce) begin
      count_ff <= nxt_count;
      done_ff  <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule // rfs_interval_timer
`default_nettype wire

/* verif/rfs_chk.sv */
// Port-level property checker for the regulator fault supervisor
`timescale 1ns/10ps
`default_nettype none
module rfs_chk #(
  parameter int unsigned PG_DELAY_CYC = rfs_pkg::PG_DELAY_CYC
) (
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire rfs_pkg::rfs_pin_type      pins_async,
  input wire rfs_pkg::rfs_scenario_type scenario,
  input wire logic                     regulate_en,
  input wire logic                     core_rail_good,
  input wire logic                     aux_rail_good,
  input wire logic                     overvoltage_trip,
  input wire logic                     major_fault_n,
  input wire logic                     overcurrent_clamp_flag,
  input wire logic                     max_load_current_limit_warning,
  input wire logic [3:0]               positive_current_limit
);
  int unsigned ramp_ff;
  int unsigned nxt_ramp;
  wire logic   bias_ok = pins_async.bias_18_ok && pins_async.bias_33_ok;
  // Cycles spent regulating since the last restart
  always_comb nxt_ramp = regulate_en ? ramp_ff + 1 : 0;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) ramp_ff <= 0;
    else ramp_ff <= nxt_ramp;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------
  // Properties
  // ----------
  // Pins pass a two-flop synchroniser, hence the fixed lag of three
  property p_ovp_gate;
    overvoltage_trip |-> !core_rail_good && !aux_rail_good && !regulate_en && major_fault_n;
  endproperty
  a_ovp_gate: assert property (p_ovp_gate) else $error("ovp outputs wrong");
  property p_ovp_latch;
    overvoltage_trip && bias_ok && $past(bias_ok) && $past(bias_ok, 2) |=> overvoltage_trip;
  endproperty
  a_ovp_latch: assert property (p_ovp_latch) else $error("ovp latch lost");
  property p_fault_latch;
    !major_fault_n && bias_ok && $past(bias_ok) && $past(bias_ok, 2) |=> !major_fault_n;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault latch lost");
  property p_flag;
    $rose(overcurrent_clamp_flag) |-> $past(pins_async.clamp_on, 3) && scenario.flag_en;
  endproperty
  a_flag: assert property (p_flag) else $error("clamp flag without clamp");
  property p_icc; $rose(max_load_current_limit_warning) |-> $past(pins_async.max_load_current_limit_over, 3); endproperty
  a_icc: assert property (p_icc) else $error("load warning without cause");
  property p_lim; positive_current_limit <= 4'h9; endproperty
  a_lim: assert property (p_lim) else $error("limit selector out of range");
  property p_pg_delay; $rose(core_rail_good) |-> ramp_ff >= PG_DELAY_CYC; endproperty
  a_pg_delay: assert property (p_pg_delay) else $error("good too early");
  property p_pg_drop; core_rail_good |-> !$past(pins_async.below_tolerance, 3); endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("good while low");
  c_ovp: cover property ($rose(overvoltage_trip));
  c_fault: cover property ($fell(major_fault_n));
  c_hiccup: cover property ($fell(regulate_en) && major_fault_n && !overvoltage_trip);
endmodule // rfs_chk
bind rfs_fault_supervisor rfs_chk #(.PG_DELAY_CYC(PG_DELAY_CYC)) i_rfs_chk (.clk_sys, .rst,
  .pins_async, .scenario, .regulate_en, .core_rail_good, .aux_rail_good, .overvoltage_trip,
  .major_fault_n, .overcurrent_clamp_flag, .max_load_current_limit_warning, .positive_current_limit);
`default_nettype wire

/* verif/rfs_stage_model.sv */
// Behavioural power-stage and board pin model facing the supervisor
`timescale 1ns/10ps
`default_nettype none
module rfs_stage_model #(
  parameter int unsigned RAMP_CYC = 3
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire rfs_pkg::rfs_pin_type req,
  input  wire logic                 regulate_en,
  output var  rfs_pkg::rfs_pin_type pins
);
  int unsigned ramp_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) ramp_ff <= 0;
    else ramp_ff <= !regulate_en ? 0 : (ramp_ff < RAMP_CYC) ? ramp_ff + 1 : ramp_ff;
  end
  // Boot ramp ends only after switching; overload only flows while switching
  always_comb begin
    pins = req;
    pins.vid_start_done = req.vid_start_done && (ramp_ff >= RAMP_CYC);
    pins.clamp_on = req.clamp_on && regulate_en;
  end
endmodule // rfs_stage_model
`default_nettype wire

/* verif/rfs_fault_supervisor_tb.sv */
// Self-checking bench for the regulator fault supervisor
`timescale 1ns/10ps
`default_nettype none
module rfs_fault_supervisor_tb;
  localparam int unsigned LOG_CYC = 20;
  localparam int unsigned OFF_CYC = 40;
  localparam rfs_pkg::rfs_scenario_type SCN = '{oc_sel: 4'h3, sink_sel: 1'b1,
    continuous_limit_mode: 1'b0, flag_en: 1'b1, rebal_gain: 4'hA};
  localparam rfs_pkg::rfs_pin_type OKP = '{bias_18_ok: 1'b1, bias_33_ok: 1'b1, vin_ok: 1'b1,
    output_enable_pin: 1'b1, strap_valid: 1'b1, vid_start_done: 1'b1, default: 1'b0};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic regulate_en, core_rail_good, aux_rail_good, overvoltage_trip, major_fault_n;
  logic stage_overtemp_warning_n, overcurrent_clamp_flag, max_load_current_limit_warning, sinking_current_limit;
  logic [3:0] positive_current_limit, orthogonal_rebalancing_gain;
  rfs_pkg::rfs_pin_type p = '0;
  rfs_pkg::rfs_pin_type pa;
  int mismatches = 0;
  int checks = 0;
  always #2 clk_sys = ~clk_sys;
  rfs_stage_model i_rfs_stage_model (.clk_sys, .rst, .req(p), .regulate_en, .pins(pa));
  rfs_fault_supervisor #(.CLAMP_LOG_CYC(LOG_CYC), .HICCUP_OFF_CYC(OFF_CYC), .PG_DELAY_CYC(5))
    i_rfs_fault_supervisor (.clk_sys, .rst, .ce, .pins_async(pa), .scenario(SCN), .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .regulate_en, .core_rail_good, .aux_rail_good,
    .overvoltage_trip, .major_fault_n, .stage_overtemp_warning_n, .overcurrent_clamp_flag,
    .max_load_current_limit_warning, .positive_current_limit, .sinking_current_limit,
    .orthogonal_rebalancing_gain);
  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cy(1);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cy(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    cy(1);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cy(1);
    reg_rd <= 1'b0;
    #1 cmp(nm, exp, reg_rdata);
  endtask
  // Bounded wait; returns cycles waited
  task automatic wait_on(input bit gd, input logic lv, output int n);
    #1 n = 0;
    while (((gd ? core_rail_good : regulate_en) !== lv) && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
    end
    cmp(gd ? "good" : "reg_en", 8'(lv), 8'(gd ? core_rail_good : regulate_en));
  endtask
  task automatic bias_cycle(input logic st, input logic ph);
    rfs_pkg::rfs_pin_type v;
    v = OKP;
    v.strap_valid = st;
    v.phase_fault = ph;
    cy(1);
    p.bias_18_ok <= 1'b0;
    cy(4);
    p <= v;
  endtask
  task automatic t_boot();
    int n;
    bias_cycle(1'b1, 1'b0);
    wait_on(1'b1, 1'b1, n);
    cmp("aux", 8'h01, 8'(aux_rail_good));
    rd(8'hF9, 8'h00, "log");
    rd(8'hD3, 8'h13, "d3_dflt");
    rd(8'hD2, 8'h00, "d2_dflt");
    cmp("gain", 8'h0A, 8'(orthogonal_rebalancing_gain));
    $display("t_boot done");
  endtask
  task automatic t_regs();
    wr(8'hD3, 8'h0C);
    cy(1);
    #1 cmp("lim", 8'h09, 8'(positive_current_limit));
    cmp("sink", 8'h00, 8'(sinking_current_limit));
    wr(8'hD3, 8'h15);
    wr(8'hB4, 8'h70);
    wr(8'hF9, 8'hFF);
    #1 cmp("lim", 8'h05, 8'(positive_current_limit));
    cmp("sink", 8'h01, 8'(sinking_current_limit));
    cmp("gain", 8'h07, 8'(orthogonal_rebalancing_gain));
    cy(1);
    ce <= 1'b0;
    wr(8'hD3, 8'h1C);
    ce <= 1'b1;
    cy(2);
    #1 cmp("ce_lim", 8'h05, 8'(positive_current_limit));
    rd(8'hF9, 8'h00, "log_ro");
    rd(8'h55, 8'h00, "unmapped");
    $display("t_regs done");
  endtask
  task automatic t_cont();
    wr(8'hD2, 8'h80);
    cy(1);
    p.clamp_on <= 1'b1;
    cy(LOG_CYC - 5);
    p.clamp_on <= 1'b0;
    rd(8'hF9, 8'h00, "short_clamp");
    cy(1);
    p.clamp_on <= 1'b1;
    p.max_load_current_limit_over <= 1'b1;
    cy(LOG_CYC + 10);
    #1 cmp("reg_en", 8'h01, 8'(regulate_en));
    cmp("flag", 8'h01, 8'(overcurrent_clamp_flag));
    cmp("icc", 8'h01, 8'(max_load_current_limit_warning));
    rd(8'hF9, 8'h40, "clamp_log");
    cy(1);
    p.clamp_on <= 1'b0;
    p.max_load_current_limit_over <= 1'b0;
    cy(4);
    #1 cmp("flag", 8'h00, 8'(overcurrent_clamp_flag));
    $display("t_cont done");
  endtask
  task automatic t_hiccup();
    int n;
    wr(8'hD2, 8'h00);
    cy(1);
    p.clamp_on <= 1'b1;
    wait_on(1'b0, 1'b0, n);
    cmp("on_t", 8'h01, 8'(n >= LOG_CYC && n <= LOG_CYC + 8));
    wait_on(1'b0, 1'b1, n);
    cmp("off_t", 8'h01, 8'(n >= OFF_CYC && n <= OFF_CYC + 5));
    wait_on(1'b0, 1'b0, n);
    cy(1);
    p.clamp_on <= 1'b0;
    wait_on(1'b1, 1'b1, n);
    cy(2 * LOG_CYC);
    #1 cmp("reg_en", 8'h01, 8'(regulate_en));
    $display("t_hiccup done");
  endtask
  task automatic t_vin();
    int n;
    cy(1);
    p.vin_ok <= 1'b0;
    wait_on(1'b0, 1'b0, n);
    rd(8'hD3, 8'h15, "cfg_kept");
    cy(1);
    p.vin_ok <= 1'b1;
    wait_on(1'b1, 1'b1, n);
    cy(1);
    p.below_tolerance <= 1'b1;
    p.stage_hot <= 1'b1;
    cy(4);
    #1 cmp("good", 8'h00, 8'(core_rail_good));
    cmp("hot_n", 8'h00, 8'(stage_overtemp_warning_n));
    cmp("reg_en", 8'h01, 8'(regulate_en));
    cy(1);
    p.below_tolerance <= 1'b0;
    p.stage_hot <= 1'b0;
    wait_on(1'b1, 1'b1, n);
    $display("t_vin done");
  endtask
  task automatic t_ovp();
    int n;
    for (int i = 0; i < 2; i++) begin
      cy(1);
      p.ovp_track <= (i == 0);
      p.ovp_umbrella <= (i == 1);
      cy(5);
      p.ovp_track <= 1'b0;
      p.ovp_umbrella <= 1'b0;
      cy(5);
      #1 cmp("ovp", 8'h01, 8'(overvoltage_trip));
      cmp("goods", 8'h00, {6'h00, core_rail_good, aux_rail_good});
      cmp("fault_n", 8'h01, 8'(major_fault_n));
      cmp("reg_en", 8'h00, 8'(regulate_en));
      rd(8'hF9, (i == 0) ? 8'hC0 : 8'h80, "log_ovp");
      bias_cycle(1'b1, 1'b0);
      cy(4);
      #1 cmp("ovp", 8'h00, 8'(overvoltage_trip));
      rd(8'hD3, 8'h13, "cfg_reload");
      wait_on(1'b1, 1'b1, n);
    end
    $display("t_ovp done");
  endtask
  task automatic t_faults();
    cy(1);
    p.stage_temp_sense_low <= 1'b1;
    cy(5);
    p.stage_temp_sense_low <= 1'b0;
    cy(8);
    #1 cmp("fault_n", 8'h00, 8'(major_fault_n));
    cmp("reg_en", 8'h00, 8'(regulate_en));
    rd(8'hF9, 8'h20, "log_stage");
    bias_cycle(1'b0, 1'b0);
    cy(10);
    #1 cmp("fault_n", 8'h00, 8'(major_fault_n));
    rd(8'hF9, 8'h02, "log_strap");
    bias_cycle(1'b1, 1'b1);
    cy(10);
    #1 cmp("reg_en", 8'h00, 8'(regulate_en));
    rd(8'hF9, 8'h10, "log_phase");
    $display("t_faults done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    cy(12);
    rst <= 1'b0;
    t_boot();
    t_regs();
    t_cont();
    t_hiccup();
    t_vin();
    t_ovp();
    t_faults();
    conclude();
  end
  // Runs take a few hundred cycles
  initial begin
    cy(20000);
    mismatches++;
    conclude();
  end
endmodule // rfs_fault_supervisor_tb
`default_nettype wire
